// file: include/gpio_bank_map.vh
// register map, reset values and pin groupings of the I/O port bank
`ifndef GPIO_BANK_MAP_VH
`define GPIO_BANK_MAP_VH

`define PORT_COUNT 9
`define PORT_WIDTH 8
`define PIN_COUNT 72
`define ADDR_WIDTH 9

// port slot: byte address = port index * 16 + register offset
`define PORT_SLOT_SHIFT 4
`define OFS_PIN_LEVEL 4'h0
`define OFS_OUTPUT_LATCH 4'h4
`define OFS_DIRECTION 4'h8
`define OFS_INTR_CTRL_2 9'h100

// port indices (A=0 .. J=8, no I)
`define PORT_IDX_B 4'h1
`define PORT_IDX_D 4'h3
`define PORT_IDX_E 4'h4
`define PORT_IDX_G 4'h6
`define PORT_IDX_H 4'h7
`define PORT_IDX_J 4'h8

// reset values
`define RST_DIRECTION 8'hFF
`define RST_DIRECTION_G 8'h1F
`define RST_OUTPUT_LATCH 8'h00
`define RST_INTR_CTRL_2 8'h00
`define RST_PULLUP 1'b0

// control bit positions
`define BIT_PULLUP_B 7
`define BIT_PULLUP_D 7
`define BIT_PULLUP_E 6
`define BIT_PULLUP_J 5
`define BIT_OD_USART1 7
`define BIT_OD_USART2 6
`define BIT_OD_SPI 7
`define BIT_OD_CCP2 6
`define BIT_OD_CCP1 5

// port G has five real pins; upper bits carry control
`define PIN_MASK_G 8'h1F

// pins (port * 8 + bit) owned by each open-drain capable module
`define PINS_USART1 72'h000000000000C00000
`define PINS_USART2 72'h000006000000000000
`define PINS_SPI 72'h000000000000280000
`define PINS_CCP1 72'h000000000000040000
`define PINS_CCP2 72'h000000000000020000

`endif

// file: logic/pin_sync.v
// two-stage synchroniser for the pin input levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // clock and reset
  input wire clock,
  input wire srst,
  // asynchronous pin levels in, synchronised levels out
  input wire [71:0] async_in,
  output reg [71:0] sync_out
);

  reg [71:0] stage1_ff;

  always @(posedge clock) begin
    if (srst) begin
      stage1_ff <= 72'h000000000000000000;
      sync_out <= 72'h000000000000000000;
    end else begin
      stage1_ff <= async_in;
      sync_out <= stage1_ff;
    end
  end

endmodule // pin_sync
`default_nettype wire

// file: logic/pad_drive.v
// per-pin output driver selection: gpio, peripheral, open-drain
`timescale 1ns/1ps
`default_nettype none
module pad_drive (
  // clock and reset
  input wire clock,
  input wire srst,
  // gpio state
  input wire [71:0] direction,
  input wire [71:0] latch,
  input wire [71:0] pin_present,
  // peripheral takeover
  input wire [71:0] periph_en,
  input wire [71:0] periph_out,
  input wire [71:0] periph_oe,
  input wire [71:0] open_drain,
  // pad controls
  output reg [71:0] pad_out,
  output reg [71:0] pad_oe
);

  genvar i;
  generate
    for (i = 0; i < 72; i = i + 1) begin : g_pin
      wire drv_val;
      wire drv_en;
      // peripheral wins over the gpio latch
      assign drv_val = periph_en[i] ? periph_out[i] : latch[i];
      assign drv_en = periph_en[i] ? periph_oe[i] : ~direction[i];
      always @(posedge clock) begin
        if (srst) begin
          pad_out[i] <= 1'b0;
          pad_oe[i] <= 1'b0;
        end else if (!pin_present[i]) begin
          pad_out[i] <= 1'b0;
          pad_oe[i] <= 1'b0;
        end else if (open_drain[i]) begin
          // drive low only; high is left to the external pull-up
          pad_out[i] <= 1'b0;
          pad_oe[i] <= drv_en & ~drv_val;
        end else begin
          pad_out[i] <= drv_val;
          pad_oe[i] <= drv_en;
        end
      end
    end
  endgenerate

endmodule // pad_drive
`default_nettype wire

// file: logic/general_io_port_bank.v
// bank of nine general-purpose I/O ports behind an Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none
`include "gpio_bank_map.vh"

// Notes on behaviour
// - There are nine ports, each with direction, pin-level and output-latch registers.
// - A pin whose sharing peripheral is enabled is driven by that peripheral, not by gpio.
// - Reading a pin-level register returns the levels present on the pins; for port G, bits 7:5 return the pull-up enables.
// - Writing a pin-level register stores the value into that port's output latch; for port G, only bits 4:0 go to the latch.
// - A direction bit of 1 makes the pin an input with its driver released.
// - A direction bit of 0 makes the pin drive its output latch bit.
// - Reading the output latch returns the latched values, not the pin levels.
// - Ports B, D, E and J have weak pull-ups, each port enabled by one bit.
// - The port B pull-up enable is bit 7 of the second interrupt control register.
// - Pull-up enables for D, E and J are bits 7, 6, 5 of the port G pin-level register.
// - Serial, sync-serial and capture/compare output pins have open-drain options in port G.
// - With open-drain on, the pin is only driven low and released for high.
// - Ports H and J exist only on the larger package and are absent otherwise.
module general_io_port_bank (
  // clock and reset
  input wire clock,
  input wire srst,
  // Avalon-MM slave
  input wire [8:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output reg waitrequest,
  // package strap, sampled during reset
  input wire large_package,
  // device pins: level in, drive value, drive enable, weak pull-up
  input wire [71:0] pin_in,
  output wire [71:0] pin_out,
  output wire [71:0] pin_oe,
  output reg [71:0] pin_pullup,
  // peripherals sharing the pins
  input wire [71:0] periph_en,
  input wire [71:0] periph_out,
  input wire [71:0] periph_oe
);

  // register state
  reg [71:0] direction_reg_ff;
  reg [71:0] output_latch_reg_ff;
  reg [7:0] intr_ctrl_2_ff;
  reg pullup_en_d_ff;
  reg pullup_en_e_ff;
  reg pullup_en_j_ff;
  reg large_meta_ff;
  reg large_sync_ff;
  reg large_pkg_ff;

  wire [71:0] pin_sync_lvl;
  wire [71:0] pin_present;
  wire [71:0] open_drain;
  wire [7:0] direction_reg_g;
  wire [7:0] output_latch_g;
  wire [7:0] pin_level_g;
  wire pullup_en_b;

  // address decode
  wire req;
  wire slot_hit;
  wire [3:0] port_sel;
  wire [3:0] reg_ofs;
  wire ctrl2_hit;
  wire port_absent;
  wire wr_lane0;

  assign req = read | write;
  assign port_sel = address[7:4];
  assign reg_ofs = address[3:0];
  assign ctrl2_hit = (address == `OFS_INTR_CTRL_2);
  assign port_absent = ~large_pkg_ff &
    ((port_sel == `PORT_IDX_H) | (port_sel == `PORT_IDX_J));
  assign slot_hit = ~address[8] & (port_sel < `PORT_COUNT) & ~port_absent &
    ((reg_ofs == `OFS_PIN_LEVEL) | (reg_ofs == `OFS_OUTPUT_LATCH) |
     (reg_ofs == `OFS_DIRECTION));
  // only the low byte carries data; other lanes are ignored
  assign wr_lane0 = byteenable[0];

  assign direction_reg_g = direction_reg_ff[55:48];
  assign output_latch_g = output_latch_reg_ff[55:48];
  assign pullup_en_b = intr_ctrl_2_ff[`BIT_PULLUP_B];

  // upper port G bits read back the pull-up controls
  assign pin_level_g = {pullup_en_d_ff, pullup_en_e_ff, pullup_en_j_ff,
    pin_sync_lvl[52:48]};

  // which pins physically exist
  genvar p;
  generate
    for (p = 0; p < 9; p = p + 1) begin : g_present
      if (p == 6) begin : g_g
        assign pin_present[p*8 +: 8] = `PIN_MASK_G;
      end else if (p >= 7) begin : g_hj
        assign pin_present[p*8 +: 8] = {8{large_pkg_ff}};
      end else begin : g_std
        assign pin_present[p*8 +: 8] = 8'hFF;
      end
    end
  endgenerate

  // open-drain selection per module, only for peripheral-owned pins
  assign open_drain = periph_en & (
    ({72{output_latch_g[`BIT_OD_USART1]}} & `PINS_USART1) |
    ({72{output_latch_g[`BIT_OD_USART2]}} & `PINS_USART2) |
    ({72{direction_reg_g[`BIT_OD_SPI]}} & `PINS_SPI) |
    ({72{direction_reg_g[`BIT_OD_CCP2]}} & `PINS_CCP2) |
    ({72{direction_reg_g[`BIT_OD_CCP1]}} & `PINS_CCP1));

  pin_sync u_pin_sync (
    .clock(clock),
    .srst(srst),
    .async_in(pin_in),
    .sync_out(pin_sync_lvl)
  );

  pad_drive u_pad_drive (
    .clock(clock),
    .srst(srst),
    .direction(direction_reg_ff),
    .latch(output_latch_reg_ff),
    .pin_present(pin_present),
    .periph_en(periph_en),
    .periph_out(periph_out),
    .periph_oe(periph_oe),
    .open_drain(open_drain),
    .pad_out(pin_out),
    .pad_oe(pin_oe)
  );

  // package strap: synchronised, loaded while srst is high and held once it falls
  always @(posedge clock) begin
    large_meta_ff <= large_package;
    large_sync_ff <= large_meta_ff;
    if (srst) begin
      large_pkg_ff <= large_sync_ff;
    end
  end

  // read mux
  reg [7:0] nxt_rd_byte;
  always @* begin
    nxt_rd_byte = 8'h00;
    if (ctrl2_hit) begin
      nxt_rd_byte = intr_ctrl_2_ff;
    end else if (slot_hit) begin
      case (reg_ofs)
        `OFS_PIN_LEVEL: begin
          if (port_sel == `PORT_IDX_G) begin
            nxt_rd_byte = pin_level_g;
          end else begin
            nxt_rd_byte = pin_sync_lvl[port_sel*8 +: 8];
          end
        end
        `OFS_OUTPUT_LATCH: nxt_rd_byte = output_latch_reg_ff[port_sel*8 +: 8];
        `OFS_DIRECTION: nxt_rd_byte = direction_reg_ff[port_sel*8 +: 8];
        default: nxt_rd_byte = 8'h00;
      endcase
    end
  end

  // bus handshake: answer one cycle after the request appears
  wire accept;
  assign accept = waitrequest & req;

  always @(posedge clock) begin
    if (srst) begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end else if (accept) begin
      waitrequest <= 1'b0;
      readdata <= {24'h000000, (read ? nxt_rd_byte : 8'h00)};
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // register writes
  integer k;
  always @(posedge clock) begin
    if (srst) begin
      for (k = 0; k < 9; k = k + 1) begin
        direction_reg_ff[k*8 +: 8] <= `RST_DIRECTION;
        output_latch_reg_ff[k*8 +: 8] <= `RST_OUTPUT_LATCH;
      end
      // upper port G direction bits are open-drain controls, off at reset
      direction_reg_ff[55:48] <= `RST_DIRECTION_G;
      intr_ctrl_2_ff <= `RST_INTR_CTRL_2;
      pullup_en_d_ff <= `RST_PULLUP;
      pullup_en_e_ff <= `RST_PULLUP;
      pullup_en_j_ff <= `RST_PULLUP;
    end else if (!waitrequest && write && wr_lane0) begin
      // commit on the answer edge, the one edge the master counts as done
      if (ctrl2_hit) begin
        intr_ctrl_2_ff <= writedata[7:0];
      end else if (slot_hit) begin
        case (reg_ofs)
          `OFS_PIN_LEVEL: begin
            if (port_sel == `PORT_IDX_G) begin
              // low bits go to the latch, upper bits are pull-up controls
              output_latch_reg_ff[52:48] <= writedata[4:0];
              pullup_en_d_ff <= writedata[`BIT_PULLUP_D];
              pullup_en_e_ff <= writedata[`BIT_PULLUP_E];
              pullup_en_j_ff <= writedata[`BIT_PULLUP_J];
            end else begin
              output_latch_reg_ff[port_sel*8 +: 8] <= writedata[7:0];
            end
          end
          `OFS_OUTPUT_LATCH: output_latch_reg_ff[port_sel*8 +: 8] <= writedata[7:0];
          `OFS_DIRECTION: direction_reg_ff[port_sel*8 +: 8] <= writedata[7:0];
          default: begin
          end
        endcase
      end
    end
  end

  // weak pull-ups, one enable per port
  always @(posedge clock) begin
    if (srst) begin
      pin_pullup <= 72'h000000000000000000;
    end else begin
      pin_pullup <= 72'h000000000000000000;
      pin_pullup[15:8] <= {8{pullup_en_b}};
      pin_pullup[31:24] <= {8{pullup_en_d_ff}};
      pin_pullup[39:32] <= {8{pullup_en_e_ff}};
      pin_pullup[71:64] <= {8{pullup_en_j_ff & large_pkg_ff}};
    end
  end

endmodule // general_io_port_bank
`default_nettype wire

// file: test/pin_world.sv
// board model beside the pins: external drivers and pull-up resistors
`timescale 1ns/1ps
`default_nettype none
module pin_world (
  // device pads
  input wire logic [71:0] pin_out,
  input wire logic [71:0] pin_oe,
  // external drivers
  input wire logic [71:0] ext_val,
  input wire logic [71:0] ext_en,
  // resolved level
  output logic [71:0] pin_lvl
);
  // pins nobody drives rest high on board resistors, as open-drain needs
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | ~ext_en));
endmodule // pin_world
`default_nettype wire

// file: test/general_io_port_bank_chk.sv
// concurrent checks on the port bank's bus handshake and pins
`timescale 1ns/1ps
`default_nettype none
module gpio_bank_chk (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // bus
  input wire logic [8:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // strap and pins
  input wire logic large_package,
  input wire logic [71:0] pin_in,
  input wire logic [71:0] pin_out,
  input wire logic [71:0] pin_oe,
  input wire logic [71:0] pin_pullup,
  // peripherals
  input wire logic [71:0] periph_en,
  input wire logic [71:0] periph_out,
  input wire logic [71:0] periph_oe
);
  localparam logic [71:0] OD_PINS = 72'h000006000000EE0000;
  logic pkg_ff;
  always_ff @(posedge clock) if (srst) pkg_ff <= large_package;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  wait_answer_a: assert property ((read | write) && waitrequest |=> !waitrequest)
    else $error("request not answered in one cycle");
  answer_once_a: assert property (!waitrequest |=> waitrequest)
    else $error("answer longer than one cycle");
  idle_wait_a: assert property (waitrequest && !read && !write |=> waitrequest)
    else $error("answer without request");
  rd_upper_a: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  periph_take_a: assert property (!$past(srst) |-> ((({pin_oe, pin_out} ^
    $past({periph_oe, periph_out})) & {2{$past(periph_en) & ~OD_PINS}}) == 144'h0))
    else $error("peripheral does not own its pin");
  pullup_ports_a: assert property ((pin_pullup & ~72'hFF000000FFFF00FF00) == 72'h0)
    else $error("pull-up on a port without pull-ups");
  pullup_group_a: assert property ($stable(pin_pullup[15:8]) or
    pin_pullup[15:8] == 8'h00 || pin_pullup[15:8] == 8'hFF)
    else $error("port pull-ups split");
  reset_quiet_a: assert property ($fell(srst) |-> pin_oe == 72'h0 && waitrequest)
    else $error("pins driven after reset");
  absent_ports_a: assert property (!pkg_ff |-> (pin_oe[71:56] | pin_pullup[71:56]) == 16'h0)
    else $error("absent port active");
endmodule // gpio_bank_chk
`default_nettype wire

// file: test/testbench.sv
// self-checking bench for the port bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock, srst, read, write, waitrequest, large_package;
  logic [8:0] address;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable;
  logic [71:0] pin_in, pin_out, pin_oe, pin_pullup, periph_en, periph_out, periph_oe;
  logic [71:0] ext_val, ext_en;
  logic [7:0] rdv;
  int mismatches = 0, checks_done = 0, cycles = 0;
  // write address, write data, read address, expected read
  logic [33:0] rows [6] = '{{9'h024, 8'h5A, 9'h024, 8'h5A}, {9'h020, 8'hA5, 9'h024, 8'hA5},
    {9'h028, 8'h0F, 9'h028, 8'h0F}, {9'h100, 8'h80, 9'h100, 8'h80},
    {9'h00C, 8'h77, 9'h00C, 8'h00}, {9'h1F0, 8'h77, 9'h1F0, 8'h00}};
  general_io_port_bank i_general_io_port_bank (.*);
  pin_world i_pin_world (.pin_out, .pin_oe, .ext_val, .ext_en, .pin_lvl(pin_in));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk72(input string n, input logic [71:0] e, input logic [71:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // request held until the edge that sees waitrequest low
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    writedata <= {24'h0, d};
    write <= 1'b1;
    do @(posedge clock); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a);
    @(posedge clock);
    address <= a;
    read <= 1'b1;
    do @(posedge clock); while (waitrequest !== 1'b0);
    rdv = readdata[7:0];
    read <= 1'b0;
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    {srst, read, write, address, writedata, byteenable, large_package} = {3'b100, 41'h0, 5'h3};
    {periph_en, periph_out, periph_oe, ext_val, ext_en} = {288'h0, 72'hF0000};
    ext_val = 72'h30000;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    rd(9'h008);
    chk8("dir_a", 8'hFF, rdv);
    rd(9'h004);
    chk8("latch_a", 8'h00, rdv);
    rd(9'h068);
    chk8("dir_g", 8'h1F, rdv);
    for (int i = 0; i < 6; i++) begin
      wr(rows[i][33:25], rows[i][24:17]);
      rd(rows[i][16:8]);
      chk8("row", rows[i][7:0], rdv);
    end
    repeat (5) @(posedge clock);
    chk72("oe", 72'hF00000, pin_oe);
    chk72("drive", 72'hA00000, pin_out & pin_oe);
    rd(9'h020);
    chk8("pins_c", 8'hA3, rdv);
    // lane 0 disabled: the write must be dropped
    byteenable <= 4'h0;
    wr(9'h024, 8'h11);
    byteenable <= 4'h1;
    rd(9'h024);
    chk8("latch_c", 8'hA5, rdv);
    wr(9'h060, 8'hE0);
    periph_en <= 72'h400001;
    periph_oe <= 72'h400001;
    periph_out <= 72'h400001;
    repeat (4) @(posedge clock);
    chk72("pullup", 72'hFF000000FFFF00FF00, pin_pullup);
    chk72("take", 72'hE00001, pin_out & pin_oe);
    wr(9'h064, 8'h80);
    repeat (4) @(posedge clock);
    chk72("od_high", 72'h0, pin_oe & 72'h400000);
    periph_out <= 72'h000001;
    repeat (3) @(posedge clock);
    chk72("od_low", 72'h400000, pin_oe & ~pin_out & 72'h400000);
    srst <= 1'b1;
    large_package <= 1'b0;
    periph_en <= 72'h0;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    // a present port would read back 55
    wr(9'h078, 8'h55);
    rd(9'h078);
    chk8("dir_h", 8'h00, rdv);
    wr(9'h060, 8'hE0);
    repeat (4) @(posedge clock);
    chk72("pu_small", 72'h000000FFFF000000, pin_pullup);
    end_sim();
  end
endmodule // testbench
bind general_io_port_bank gpio_bank_chk i_gpio_bank_chk (.*);
`default_nettype wire
